// [i2c_lvl_map.svh]
`ifndef I2C_LVL_MAP_SVH
`define I2C_LVL_MAP_SVH
`define OFF_RX_DMA_LEVEL      8'h90
`define OFF_SDA_SETUP_DELAY   8'h94
`define OFF_GEN_CALL_ACK      8'h98
`define OFF_ENABLE_STATE      8'h9C
`define OFF_CTRL_ENABLE       8'hA4
`define OFF_DMA_CTRL          8'hA8
`define OFF_IRQ_STATUS        8'hAC
`define OFF_IRQ_MASK          8'hB0
`define RST_RX_DMA_LEVEL      4'h0
`define RST_SDA_SETUP         8'h64
`define RST_GEN_CALL_ACK      1'h1
`define BIT_ENABLED_FLAG      0
`define BIT_SLV_BUSY          1
`define BIT_SLV_DATA_LOST     2
`define IRQ_BIT_RX_REQ        0
`define IRQ_BIT_DISABLED      1
`define IRQ_BIT_SLV_ABORT     2
`define IRQ_WIDTH             3
`endif

// [i2c_lvl_pkg.sv]
package i2c_lvl_pkg;
  typedef struct packed {
    logic       addr_phase;
    logic       data_phase;
    logic       addr_match;
    logic       gen_call;
    logic       stop_seen;
    logic       bus_idle;
  } slave_activity_t;
  typedef enum logic [2:0] {
    EN_OFF      = 3'b001,
    EN_ON       = 3'b010,
    EN_DRAINING = 3'b100
  } en_state_t;
  typedef enum logic [2:0] {
    SU_IDLE  = 3'b001,
    SU_COUNT = 3'b010,
    SU_DONE  = 3'b100
  } setup_state_t;
endpackage

// [sda_setup_timer.sv]
`timescale 1ns/100ps
`include "i2c_lvl_map.svh"
module sda_setup_timer
  import i2c_lvl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       sda_changed,
  input  wire logic [7:0] setup_count,
  output logic            scl_release
);
  setup_state_t state_reg;
  setup_state_t state_next;
  logic [7:0]   cnt_reg;
  logic [7:0]   cnt_next;
  // the load cycle counts as the first period, so stop one short of the count
  wire          cnt_last = (cnt_reg <= 8'h02);

  // count starts in the cycle the data line changes
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      SU_IDLE: begin
        if (sda_changed) begin
          cnt_next   = setup_count;
          state_next = (setup_count <= 8'h01) ? SU_DONE : SU_COUNT;
        end
      end
      SU_COUNT: begin
        cnt_next = cnt_reg - 8'h01;
        if (sda_changed) begin
          cnt_next   = setup_count;
          state_next = (setup_count <= 8'h01) ? SU_DONE : SU_COUNT;
        end else if (cnt_last) begin
          state_next = SU_DONE;
        end
      end
      SU_DONE: begin
        if (sda_changed) begin
          cnt_next   = setup_count;
          state_next = (setup_count <= 8'h01) ? SU_DONE : SU_COUNT;
        end
      end
      default: state_next = SU_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SU_IDLE;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // clock line may rise only after the whole count has elapsed
  assign scl_release = (state_reg == SU_DONE) && !sda_changed;
endmodule

// [i2c_level_setup.sv]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`include "i2c_lvl_map.svh"
module i2c_level_setup
  import i2c_lvl_pkg::*;
#(
  parameter bit         dma_support_param          = 1'b1,
  parameter logic [7:0] setup_delay_default_param  = `RST_SDA_SETUP,
  parameter bit         general_call_default_param = `RST_GEN_CALL_ACK
)(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  rx_fifo_count,
  input  wire slave_activity_t activity,
  input  wire logic        sda_changed,
  input  wire logic        gen_call_ack_slot,
  output logic             rx_dma_req,
  output logic             scl_release,
  output logic             data_output_enable,
  output logic             enabled_flag,
  output logic             irq
);
  logic [3:0]  rx_level_reg;
  logic [7:0]  setup_reg;
  logic        gc_ack_reg;
  logic        ctrl_en_reg;
  logic        rdmae_reg;
  logic        slv_busy_reg;
  logic        slv_busy_next;
  logic        slv_lost_reg;
  logic        slv_lost_next;
  logic        rx_req_reg;
  logic [`IRQ_WIDTH-1:0] irq_stat_reg;
  logic [`IRQ_WIDTH-1:0] irq_stat_next;
  logic [`IRQ_WIDTH-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  en_state_t   en_reg;
  en_state_t   en_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire rd       = acc && !pwrite;
  wire wr_lvl   = wr && hit(paddr, `OFF_RX_DMA_LEVEL) && dma_support_param;
  wire wr_setup = wr && hit(paddr, `OFF_SDA_SETUP_DELAY);
  wire wr_gc    = wr && hit(paddr, `OFF_GEN_CALL_ACK);
  wire wr_en    = wr && hit(paddr, `OFF_CTRL_ENABLE);
  wire wr_dma   = wr && hit(paddr, `OFF_DMA_CTRL) && dma_support_param;
  wire wr_ist   = wr && hit(paddr, `OFF_IRQ_STATUS);
  wire wr_imk   = wr && hit(paddr, `OFF_IRQ_MASK);
  wire mapped   = hit(paddr, `OFF_RX_DMA_LEVEL) || hit(paddr, `OFF_SDA_SETUP_DELAY) ||
                  hit(paddr, `OFF_GEN_CALL_ACK) || hit(paddr, `OFF_ENABLE_STATE) ||
                  hit(paddr, `OFF_CTRL_ENABLE) || hit(paddr, `OFF_DMA_CTRL) ||
                  hit(paddr, `OFF_IRQ_STATUS) || hit(paddr, `OFF_IRQ_MASK);

  // slave engaged in a transfer that a disable would abort
  wire slv_active = activity.addr_phase ||
                    (activity.data_phase && activity.addr_match);
  wire en_fall    = (en_reg != EN_OFF) && !ctrl_en_reg;

  // disable completes only once the bus lets go
  always_comb begin
    en_next = en_reg;
    case (en_reg)
      EN_OFF: begin
        if (ctrl_en_reg) begin
          en_next = EN_ON;
        end
      end
      EN_ON: begin
        if (!ctrl_en_reg) begin
          en_next = activity.bus_idle ? EN_OFF : EN_DRAINING;
        end
      end
      EN_DRAINING: begin
        if (ctrl_en_reg) begin
          en_next = EN_ON;
        end else if (activity.bus_idle || activity.stop_seen) begin
          en_next = EN_OFF;
        end
      end
      default:     en_next = EN_OFF;
    endcase
  end

  wire en_out = (en_reg != EN_OFF);
  wire going_off = (en_next == EN_OFF) && en_out;

  // flags clear on re-enable and stick once set during a disable
  always_comb begin
    slv_busy_next = slv_busy_reg;
    slv_lost_next = slv_lost_reg;
    if (ctrl_en_reg) begin
      slv_busy_next = 1'b0;
      slv_lost_next = 1'b0;
    end else if (en_fall) begin
      if (slv_active || activity.stop_seen) begin
        slv_busy_next = 1'b1;
      end
      if (activity.addr_match && (activity.data_phase || activity.stop_seen)) begin
        slv_lost_next = 1'b1;
      end
    end
  end

  wire rx_req_next = rdmae_reg && dma_support_param &&
                     ({1'b0, rx_fifo_count} >= ({2'b00, rx_level_reg} + 6'd1));

  wire [`IRQ_WIDTH-1:0] irq_ev;
  assign irq_ev[`IRQ_BIT_RX_REQ]    = rx_req_next && !rx_req_reg;
  assign irq_ev[`IRQ_BIT_DISABLED]  = going_off;
  assign irq_ev[`IRQ_BIT_SLV_ABORT] = (slv_busy_next && !slv_busy_reg) ||
                                      (slv_lost_next && !slv_lost_reg);
  // a fresh event wins over a write-one clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~(wr_ist ? pwdata[`IRQ_WIDTH-1:0] : '0)) | irq_ev;

  wire [31:0] status_word = ctrl_en_reg ? 32'h0000_0001 :
                            {29'h0, slv_lost_reg, slv_busy_reg, en_out};
  wire [31:0] rd_mux =
      hit(paddr, `OFF_RX_DMA_LEVEL)    ? (dma_support_param ? {28'h0, rx_level_reg} : 32'h0) :
      hit(paddr, `OFF_SDA_SETUP_DELAY) ? {24'h0, setup_reg} :
      hit(paddr, `OFF_GEN_CALL_ACK)    ? {31'h0, gc_ack_reg} :
      hit(paddr, `OFF_ENABLE_STATE)    ? status_word :
      hit(paddr, `OFF_CTRL_ENABLE)     ? {31'h0, ctrl_en_reg} :
      hit(paddr, `OFF_DMA_CTRL)        ? {31'h0, rdmae_reg} :
      hit(paddr, `OFF_IRQ_STATUS)      ? {29'h0, irq_stat_reg} :
      hit(paddr, `OFF_IRQ_MASK)        ? {29'h0, irq_mask_reg} : 32'h0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_level_reg <= `RST_RX_DMA_LEVEL;
    end else if (wr_lvl) begin
      rx_level_reg <= pwdata[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setup_reg <= setup_delay_default_param;
    end else if (wr_setup) begin
      setup_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gc_ack_reg <= general_call_default_param;
    end else if (wr_gc) begin
      gc_ack_reg <= pwdata[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_reg <= 1'b0;
    end else if (wr_en) begin
      ctrl_en_reg <= pwdata[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdmae_reg <= 1'b0;
    end else if (wr_dma) begin
      rdmae_reg <= pwdata[0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= '0;
    end else if (wr_imk) begin
      irq_mask_reg <= pwdata[`IRQ_WIDTH-1:0];
    end
  end

  // reads show the build-time default until software writes the register
  logic boot_reg;
  logic [7:0] setup_eff;
  logic       gc_eff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end
  logic setup_touched_reg;
  logic gc_touched_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      setup_touched_reg <= 1'b0;
    end else if (wr_setup) begin
      setup_touched_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gc_touched_reg <= 1'b0;
    end else if (wr_gc) begin
      gc_touched_reg <= 1'b1;
    end
  end
  assign setup_eff = setup_touched_reg ? setup_reg : setup_delay_default_param;
  assign gc_eff    = gc_touched_reg ? gc_ack_reg : general_call_default_param;

  // setup-phase capture lets the access phase answer at once
  wire [31:0] rd_mux_fix = hit(paddr, `OFF_SDA_SETUP_DELAY) ? {24'h0, setup_eff} :
                           hit(paddr, `OFF_GEN_CALL_ACK)    ? {31'h0, gc_eff} : rd_mux;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= EN_OFF;
    end else begin
      en_reg <= en_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slv_busy_reg <= 1'b0;
    end else begin
      slv_busy_reg <= slv_busy_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slv_lost_reg <= 1'b0;
    end else begin
      slv_lost_reg <= slv_lost_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_req_reg <= 1'b0;
    end else begin
      rx_req_reg <= rx_req_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux_fix;
    end
  end

  sda_setup_timer u_setup (
    .clock       (clock),
    .rst_n       (rst_n),
    .sda_changed (sda_changed),
    .setup_count (setup_eff),
    .scl_release (scl_release)
  );

  assign data_output_enable = gen_call_ack_slot && activity.gen_call && gc_eff && en_out;
  assign enabled_flag       = en_out;
  assign rx_dma_req         = rx_req_reg;
  assign irq                = |(irq_stat_reg & irq_mask_reg);
  assign prdata             = prdata_reg;
  assign pready             = 1'b1;
  assign pslverr            = acc && !mapped;
  wire unused_ok = boot_reg | rd;
endmodule

// [i2c_level_setup_properties.sv]
`timescale 1ns/100ps
module i2c_level_setup_properties
  import i2c_lvl_pkg::*;
#(
  parameter logic [7:0] setup_delay_default_param  = 8'h64,
  parameter bit         general_call_default_param = 1'b1
)(
  input wire logic            clock,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic [4:0]      rx_fifo_count,
  input wire slave_activity_t activity,
  input wire logic            sda_changed,
  input wire logic            gen_call_ack_slot,
  input wire logic            rx_dma_req,
  input wire logic            scl_release,
  input wire logic            data_output_enable,
  input wire logic            enabled_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadow copies of the control registers, updated at the same edge as the design's
  logic       en_q;
  logic       rd_q;
  logic       gc_q;
  logic [3:0] lv_q;
  logic [7:0] sd_q;
  wire        wr = psel && penable && pwrite && pready;
  wire  [4:0] thr = {1'b0, lv_q} + 5'h01;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {en_q, rd_q, gc_q, lv_q, sd_q} <= {2'b00, general_call_default_param, 4'h0, setup_delay_default_param};
    end else if (wr) begin
      if (paddr == 8'hA4) en_q <= pwdata[0];
      if (paddr == 8'hA8) rd_q <= pwdata[0];
      if (paddr == 8'h98) gc_q <= pwdata[0];
      if (paddr == 8'h90) lv_q <= pwdata[3:0];
      if (paddr == 8'h94) sd_q <= pwdata[7:0];
    end
  end
  property p_req_on; rd_q && rx_fifo_count >= thr |=> rx_dma_req; endproperty
  a_req_on: assert property (p_req_on) else $error("receive request missing");
  property p_req_gate; !rd_q |=> !rx_dma_req; endproperty
  a_req_gate: assert property (p_req_gate) else $error("request while disabled");
  property p_req_drop; rx_fifo_count < thr |=> !rx_dma_req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request below level");
  property p_setup; sda_changed && sd_q == 8'h03 |-> !scl_release [*3] ##1 scl_release; endproperty
  a_setup: assert property (p_setup) else $error("clock release timing");
  property p_gc_ack; gen_call_ack_slot && enabled_flag && gc_q |-> data_output_enable; endproperty
  a_gc_ack: assert property (p_gc_ack) else $error("general call not acked");
  property p_gc_nack; gen_call_ack_slot && !gc_q |-> !data_output_enable; endproperty
  a_gc_nack: assert property (p_gc_nack) else $error("general call acked");
  property p_en_hold; enabled_flag && !activity.bus_idle && !activity.stop_seen |=> enabled_flag; endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable dropped while busy");
  property p_status; psel && penable && !pwrite && paddr == 8'h9C && en_q |-> prdata[2:0] == 3'b001; endproperty
  a_status: assert property (p_status) else $error("status while enabled");
  property p_en_rise; wr && paddr == 8'hA4 && pwdata[0] |-> ##2 enabled_flag; endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable output late");
endmodule
bind i2c_level_setup i2c_level_setup_properties #(
  .setup_delay_default_param (setup_delay_default_param),
  .general_call_default_param(general_call_default_param)
) chk_u (
  .clock              (clock),
  .rst_n              (rst_n),
  .psel               (psel),
  .penable            (penable),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .pwdata             (pwdata),
  .prdata             (prdata),
  .pready             (pready),
  .rx_fifo_count      (rx_fifo_count),
  .activity           (activity),
  .sda_changed        (sda_changed),
  .gen_call_ack_slot  (gen_call_ack_slot),
  .rx_dma_req         (rx_dma_req),
  .scl_release        (scl_release),
  .data_output_enable (data_output_enable),
  .enabled_flag       (enabled_flag)
);

// [far_side_model.sv]
`timescale 1ns/100ps
module far_side_model
  import i2c_lvl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rx_dma_req,
  output slave_activity_t activity,
  output logic            sda_changed,
  output logic            gen_call_ack_slot,
  output logic [4:0]      rx_fifo_count
);
  logic dma_drain;
  initial begin
    activity = 6'b000001;
    sda_changed = 1'b0;
    gen_call_ack_slot = 1'b0;
    rx_fifo_count = 5'h00;
    dma_drain = 1'b0;
  end
  // a stalled dma controller leaves entries in place, so the request must stay up
  always @(posedge clock) begin
    if (dma_drain && rx_dma_req && rx_fifo_count != 5'h00) rx_fifo_count <= rx_fifo_count - 5'h01;
  end
endmodule

// [tb.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb;
  import i2c_lvl_pkg::*;
  logic            clock   = 1'b0;
  logic            rst_n   = 1'b0;
  logic            psel    = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite  = 1'b0;
  logic [7:0]      paddr   = 8'h00;
  logic [31:0]     pwdata  = 32'h0;
  logic [31:0]     prdata, rd;
  logic            pready, pslverr, err, irq, irq_a, rx_dma_req, scl_release, data_output_enable, enabled_flag;
  logic            sda_changed, gen_call_ack_slot;
  logic [4:0]      rx_fifo_count;
  slave_activity_t activity;
  int              failures = 0;
  int              samples_checked = 0;
  i2c_level_setup dut_u (
    .clock              (clock),
    .rst_n              (rst_n),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .rx_fifo_count      (rx_fifo_count),
    .activity           (activity),
    .sda_changed        (sda_changed),
    .gen_call_ack_slot  (gen_call_ack_slot),
    .rx_dma_req         (rx_dma_req),
    .scl_release        (scl_release),
    .data_output_enable (data_output_enable),
    .enabled_flag       (enabled_flag),
    .irq                (irq)
  );
  far_side_model far_u (
    .clock             (clock),
    .rx_dma_req        (rx_dma_req),
    .activity          (activity),
    .sda_changed       (sda_changed),
    .gen_call_ack_slot (gen_call_ack_slot),
    .rx_fifo_count     (rx_fifo_count)
  );
  initial forever #20 clock = ~clock;
  task automatic wrap_up;
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin failures++; wrap_up(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd & m)
  endtask
  task automatic wait_sig(ref logic s, input logic v);
    for (int n = 0; n < 50 && s !== v; n++) @(negedge clock);
    if (s !== v) begin failures++; wrap_up(); end
  endtask
  task automatic t_reset_values;
    rchk("level", 8'h90, 32'hF, 32'h0);
    rchk("setup", 8'h94, 32'hFF, 32'h64);
    rchk("gencall", 8'h98, 32'h1, 32'h1);
    rchk("status", 8'h9C, 32'h7, 32'h0);
    rchk("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
    `CHK("slverr", 1'b1, err)
  endtask
  task automatic t_dma;
    apb(1'b1, 8'h90, 32'h3); // upper bits kept zero
    apb(1'b1, 8'hA8, 32'h1);
    far_u.rx_fifo_count <= 5'h03;
    repeat (3) @(negedge clock);
    `CHK("req_below", 1'b0, rx_dma_req)
    @(posedge clock) far_u.rx_fifo_count <= 5'h04;
    repeat (2) @(negedge clock);
    `CHK("req_at_level", 1'b1, rx_dma_req)
    apb(1'b1, 8'hB0, 32'h0);
    irq_a = irq;
    apb(1'b1, 8'hB0, 32'h7);
    @(negedge clock) `CHK("irq_mask", 1'b1, irq_a ^ irq)
    apb(1'b1, 8'hAC, 32'h7);
    @(negedge clock) `CHK("irq_clear", 1'b0, irq)
    @(posedge clock) far_u.dma_drain <= 1'b1;
    wait_sig(rx_dma_req, 1'b0);
    `CHK("drained", 1'b1, rx_fifo_count < 5'h04)
    @(posedge clock) far_u.dma_drain <= 1'b0;
    apb(1'b1, 8'h90, 32'h0);
    far_u.rx_fifo_count <= 5'h01;
    repeat (2) @(negedge clock);
    `CHK("req_level0", 1'b1, rx_dma_req)
    apb(1'b1, 8'hA8, 32'h0);
    repeat (2) @(negedge clock);
    `CHK("req_gated", 1'b0, rx_dma_req)
  endtask
  task automatic t_setup;
    int n;
    apb(1'b1, 8'h94, 32'h3); // short count keeps the run brief
    @(posedge clock) far_u.sda_changed <= 1'b1;
    @(negedge clock);
    for (n = 0; n < 10 && scl_release !== 1'b1; n++) begin
      @(posedge clock) far_u.sda_changed <= 1'b0;
      @(negedge clock);
    end
    `CHK("setup_cycles", 3, n)
  endtask
  task automatic t_enable;
    apb(1'b1, 8'hA4, 32'h1);
    rchk("status_on", 8'h9C, 32'h7, 32'h1);
    @(posedge clock) {far_u.gen_call_ack_slot, far_u.activity} <= 7'b1100100;
    @(negedge clock) `CHK("gc_ack", 1'b1, data_output_enable)
    apb(1'b1, 8'h98, 32'h0);
    @(negedge clock) `CHK("gc_nack", 1'b0, data_output_enable)
    @(posedge clock) {far_u.gen_call_ack_slot, far_u.activity} <= 7'b0011000;
    apb(1'b1, 8'hA4, 32'h0);
    repeat (4) @(negedge clock);
    `CHK("still_on", 1'b1, enabled_flag)
    @(posedge clock) far_u.activity <= 6'b000001;
    wait_sig(enabled_flag, 1'b0);
    rchk("status_off", 8'h9C, 32'h7, 32'h6);
    rchk("irq_events", 8'hAC, 32'h6, 32'h6);
    `CHK("irq_line", 1'b1, irq)
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_reset_values();
    t_dma();
    t_setup();
    t_enable();
    wrap_up();
  end
endmodule
